// >>> pkg/dlc_params.svh
`ifndef DLC_PARAMS_SVH
`define DLC_PARAMS_SVH
// word offsets as printed; bus byte address is four times these
`define DLC_IDX_GEN_CFG 8'h03
`define DLC_IDX_EQ_GAIN 8'h04
`define DLC_IDX_RSVD 8'h05
`define DLC_IDX_FAR_ADDR 8'h06
`define DLC_IDX_FAR_ALIAS 8'h07
`define DLC_IDX_IRQ_STAT 8'h10
`define DLC_IDX_IRQ_MASK 8'h11
`define DLC_IDX_STATUS 8'h12
// general config fields
`define DLC_BIT_PAR_CHK 7
`define DLC_BIT_CRC_GEN 6
`define DLC_BIT_IO_AUTO 5
`define DLC_BIT_IO_LVL 4
`define DLC_BIT_PASS 3
`define DLC_BIT_EARLY_ACK 2
`define DLC_BIT_PAR_CLR 1
`define DLC_BIT_EDGE 0
// reset values
`define DLC_RST_GEN_CFG 8'hE9
`define DLC_RST_EQ_GAIN 8'h00
`define DLC_RST_FAR_ADDR 7'h0C
`define DLC_RST_FAR_ALIAS 7'h00
// interrupt status bits
`define DLC_IRQ_PAR_ERR 0
`define DLC_IRQ_ADDR_LOAD 1
`define DLC_IRQ_ALIAS_HIT 2
`endif

// >>> pkg/dlc_pkg.sv
package dlc_pkg;
   // mapped i2c request toward the link
   typedef struct packed {
      logic valid;
      logic [6:0] addr;
      logic remote;
      logic early_ack;
   } dlc_i2c_fwd_t;
   // config outputs collected
   typedef struct packed {
      logic par_chk_en;
      logic crc_gen_en;
      logic io_supply_autodetect;
      logic io_supply_level;
      logic pass_en;
      logic pixel_strobe_edge_select;
      logic [7:0] eq_gain;
   } dlc_cfg_t;
   typedef enum logic [1:0] {
      DLC_IDLE = 2'b01,
      DLC_RESP = 2'b10
   } dlc_bus_st_t;
endpackage : dlc_pkg

// >>> hw/dlc_regs.sv
`timescale 1ns/10ps
`include "dlc_params.svh"
// How it works
// - general config bit 7 gates forward parity errors into the sticky flag, not into irq status; resets one.
// - bit 6 enables back-channel CRC generation; resets one.
// - bit 5 selects supply autodetect; else bit 4 picks 3.3V or 1.8V.
// - bit 3 enables i2c forwarding to the remote side; resets enabled.
// - bit 2 acknowledges remote writes at once; resets cleared.
// - early-acked writes are remapped to the far serializer address.
// - writing one to bit 1 clears parity error; self-clears; zero no effect.
// - bit 0 selects strobe edge: one falling (reset), zero rising.
// - far address bits 7:1 load from forward channel; reset 0x0C.
// - far address bit 0 freezes loading at the written value.
// - incoming i2c address compared with alias at 0x07; resets zero.
// - alias match replaces address with far serializer address.
// - alias zero disables matching entirely.
module dlc_regs (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   input wire logic fwd_addr_valid_i,
   input wire logic [6:0] fwd_addr_i,
   input wire logic parity_err_i,
   input wire logic adaptive_equalizer_bypass_i,
   input wire logic i2c_req_i,
   input wire logic [6:0] i2c_addr_i,
   input wire logic i2c_write_i,
   output dlc_pkg::dlc_cfg_t cfg_o,
   output logic [7:0] eq_applied_o,
   output logic parity_err_o,
   output dlc_pkg::dlc_i2c_fwd_t fwd_o,
   output logic irq_o
);
   import dlc_pkg::*;

   dlc_bus_st_t st_r;
   logic [7:0] gen_r;
   logic [7:0] eq_r;
   logic [6:0] far_device_address_r;
   logic hold_far_address_r;
   logic [6:0] far_address_alias_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic par_err_r;
   logic [31:0] rdata_r;
   logic [1:0] resp_r;
   dlc_i2c_fwd_t fwd_r;
   dlc_cfg_t cfg_r;
   logic [7:0] eq_app_r;
   logic irq_r;

   // address decode: word address is byte address over four
   wire logic [5:0] idx = avs_address_i[7:2];
   wire logic lane0 = avs_byteenable_i[0];
   wire logic take = (st_r == DLC_IDLE) && (avs_read_i || avs_write_i);
   // a write lands only at the edge where waitrequest is sampled low
   wire logic wr = (st_r == DLC_RESP) && avs_write_i && lane0;
   wire logic [7:0] wd = avs_writedata_i[7:0];
   wire logic hit_gen = idx == 6'(`DLC_IDX_GEN_CFG);
   wire logic hit_eq = idx == 6'(`DLC_IDX_EQ_GAIN);
   wire logic hit_rsvd = idx == 6'(`DLC_IDX_RSVD);
   wire logic hit_far = idx == 6'(`DLC_IDX_FAR_ADDR);
   wire logic hit_alias = idx == 6'(`DLC_IDX_FAR_ALIAS);
   wire logic hit_ist = idx == 6'(`DLC_IDX_IRQ_STAT);
   wire logic hit_imk = idx == 6'(`DLC_IDX_IRQ_MASK);
   wire logic hit_sts = idx == 6'(`DLC_IDX_STATUS);
   wire logic hit_any = hit_gen | hit_eq | hit_rsvd | hit_far | hit_alias |
                        hit_ist | hit_imk | hit_sts;

   // parity clear strobe; the stored bit never holds the one
   wire logic par_clr = wr && hit_gen && wd[`DLC_BIT_PAR_CLR];
   // software write to far address wins over the link load that cycle
   wire logic far_sw = wr && hit_far;
   wire logic far_load = fwd_addr_valid_i && !hold_far_address_r && !far_sw;

   // alias decode; zero alias never matches
   wire logic alias_hit = (far_address_alias_r != 7'h00) &&
                          (i2c_addr_i == far_address_alias_r);
   wire logic pass_on = gen_r[`DLC_BIT_PASS];
   wire logic early = gen_r[`DLC_BIT_EARLY_ACK] && i2c_write_i;
   wire logic fwd_go = i2c_req_i && pass_on && alias_hit;

   // readback mux, reserved and unmapped words read zero
   wire logic [7:0] rd_byte =
      hit_gen ? gen_r :
      hit_eq ? eq_r :
      hit_far ? {far_device_address_r, hold_far_address_r} :
      hit_alias ? {far_address_alias_r, 1'b0} :
      hit_ist ? {5'h00, irq_stat_r} :
      hit_imk ? {5'h00, irq_mask_r} :
      hit_sts ? {7'h00, par_err_r} : 8'h00;

   // interrupt events
   wire logic [2:0] ev = {fwd_go, far_load, parity_err_i};
   wire logic [2:0] ist_clr = (wr && hit_ist) ? wd[2:0] : 3'h0;
   // set wins over clear
   wire logic [2:0] ist_nxt = (irq_stat_r & ~ist_clr) | ev;

   // bus handshake: one wait cycle, then answer
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= DLC_IDLE;
      end else if (take) begin
         st_r <= DLC_RESP;
      end else begin
         st_r <= DLC_IDLE;
      end
   end

   // read data and response latch at request take
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 32'h0000_0000;
         resp_r <= 2'h0;
      end else if (take) begin
         rdata_r <= avs_read_i ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         resp_r <= hit_any ? 2'h0 : 2'h3; // decode error for unmapped
      end
   end

   // general config; bit 1 always stored as zero
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         gen_r <= `DLC_RST_GEN_CFG;
      end else if (wr && hit_gen) begin
         gen_r <= wd & ~(8'h01 << `DLC_BIT_PAR_CLR);
      end
   end

   // eq gain, alias, mask
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         eq_r <= `DLC_RST_EQ_GAIN;
         far_address_alias_r <= `DLC_RST_FAR_ALIAS;
         irq_mask_r <= 3'h0;
      end else begin
         if (wr && hit_eq) eq_r <= wd;
         if (wr && hit_alias) far_address_alias_r <= wd[7:1];
         if (wr && hit_imk) irq_mask_r <= wd[2:0];
      end
   end

   // far address: software write or auto-load from the link
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         far_device_address_r <= `DLC_RST_FAR_ADDR;
         hold_far_address_r <= 1'b0;
      end else if (far_sw) begin
         far_device_address_r <= wd[7:1];
         hold_far_address_r <= wd[0];
      end else if (far_load) begin
         far_device_address_r <= fwd_addr_i;
      end
   end

   // sticky parity error; new error beats the clear
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         par_err_r <= 1'b0;
      end else if (parity_err_i && gen_r[`DLC_BIT_PAR_CHK]) begin
         par_err_r <= 1'b1;
      end else if (par_clr) begin
         par_err_r <= 1'b0;
      end
   end

   // interrupt status and line
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         irq_stat_r <= 3'h0;
         irq_r <= 1'b0;
      end else begin
         irq_stat_r <= ist_nxt;
         irq_r <= |(ist_nxt & irq_mask_r);
      end
   end

   // remapped request to the link, one cycle after the local request
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         fwd_r <= '0;
      end else begin
         fwd_r.valid <= fwd_go;
         fwd_r.addr <= far_device_address_r;
         fwd_r.remote <= fwd_go;
         fwd_r.early_ack <= fwd_go && early;
      end
   end

   // config outputs registered; applied eq gain only when adaptive loop bypassed
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_r <= '0;
         eq_app_r <= 8'h00;
      end else begin
         cfg_r.par_chk_en <= gen_r[`DLC_BIT_PAR_CHK];
         cfg_r.crc_gen_en <= gen_r[`DLC_BIT_CRC_GEN];
         cfg_r.io_supply_autodetect <= gen_r[`DLC_BIT_IO_AUTO];
         cfg_r.io_supply_level <= gen_r[`DLC_BIT_IO_LVL];
         cfg_r.pass_en <= pass_on;
         cfg_r.pixel_strobe_edge_select <= gen_r[`DLC_BIT_EDGE];
         cfg_r.eq_gain <= eq_r;
         eq_app_r <= adaptive_equalizer_bypass_i ? eq_r : 8'h00;
      end
   end

   assign avs_waitrequest_o = (st_r == DLC_IDLE) ? 1'b1 : 1'b0;
   assign avs_readdata_o = rdata_r;
   assign avs_response_o = resp_r;
   assign cfg_o = cfg_r;
   assign eq_applied_o = eq_app_r;
   assign parity_err_o = par_err_r;
   assign fwd_o = fwd_r;
   assign irq_o = irq_r;
endmodule : dlc_regs

// >>> bench/dlc_far_ser.sv
`timescale 1ns/10ps
// far serializer: sends its id and flags bad parity on the forward channel
module dlc_far_ser (
   input wire logic clock_i,
   output logic addr_valid_o,
   output logic [6:0] addr_o,
   output logic parity_err_o
);
   initial begin
      addr_valid_o = 1'h0;
      addr_o = 7'h7F;
      parity_err_o = 1'h0;
   end
   // id word for one cycle; the line shows its inverse once it is gone
   task automatic announce(input logic [6:0] a);
      @(posedge clock_i);
      addr_valid_o <= 1'h1;
      addr_o <= a;
      @(posedge clock_i);
      addr_valid_o <= 1'h0;
      addr_o <= ~a;
   endtask : announce
   task automatic bad_parity();
      @(posedge clock_i);
      parity_err_o <= 1'h1;
      @(posedge clock_i);
      parity_err_o <= 1'h0;
   endtask : bad_parity
endmodule : dlc_far_ser

// >>> bench/dlc_regs_props.sv
`timescale 1ns/10ps
module dlc_regs_props (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [1:0] avs_response_o,
   input wire logic parity_err_i,
   input wire logic adaptive_equalizer_bypass_i,
   input wire logic i2c_req_i,
   input wire dlc_pkg::dlc_cfg_t cfg_o,
   input wire logic [7:0] eq_applied_o,
   input wire logic parity_err_o,
   input wire dlc_pkg::dlc_i2c_fwd_t fwd_o,
   input wire logic irq_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // bus answers exactly one cycle after the take edge
   a_answer_next: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("late answer");
   a_wait_back: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer held");
   a_unmapped_zero: assert property (!avs_waitrequest_o && avs_response_o == 2'h3 |-> avs_readdata_o == 32'h0) else $error("unmapped data");
   a_upper_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0) else $error("upper bits set");
   a_par_set: assert property (parity_err_i && cfg_o.par_chk_en |=> parity_err_o) else $error("parity not held");
   a_par_sticky: assert property (parity_err_o && !avs_write_i |=> parity_err_o) else $error("parity lost");
   a_eq_zero: assert property (!adaptive_equalizer_bypass_i |=> eq_applied_o == 8'h00) else $error("eq without bypass");
   a_eq_follow: assert property (adaptive_equalizer_bypass_i |=> eq_applied_o == cfg_o.eq_gain) else $error("eq mismatch");
   a_fwd_cause: assert property (!i2c_req_i |=> !fwd_o.valid) else $error("forward without request");
   c_fwd: cover property (fwd_o.valid);
   c_unmapped: cover property (!avs_waitrequest_o && avs_response_o == 2'h3);
   c_irq: cover property ($rose(irq_o));
endmodule : dlc_regs_props
bind dlc_regs dlc_regs_props chk (.clock_i, .rst_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .parity_err_i, .adaptive_equalizer_bypass_i, .i2c_req_i, .cfg_o, .eq_applied_o, .parity_err_o, .fwd_o, .irq_o);

// >>> bench/dlc_regs_tb.sv
`timescale 1ns/10ps
module dlc_regs_tb;
   import dlc_pkg::*;
   logic clock_i = 1'h0, rst_i = 1'h1, rd = 1'h0, wr = 1'h0, byp = 1'h0;
   logic rq = 1'h0, iw = 1'h0, fv, pe, wt, po, irq, i0;
   logic [7:0] ad = 8'h00, eqa;
   logic [6:0] fa, ia = 7'h00;
   logic [31:0] wd = 32'h0, rdw, rv;
   logic [1:0] rsp, rs;
   dlc_cfg_t cfg;
   dlc_i2c_fwd_t fw;
   int error_cnt = 0, compares = 0;
   always #2.5 clock_i = ~clock_i;
   dlc_regs uut (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(ad),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdw), .avs_waitrequest_o(wt),
      .avs_response_o(rsp), .fwd_addr_valid_i(fv), .fwd_addr_i(fa),
      .parity_err_i(pe), .adaptive_equalizer_bypass_i(byp), .i2c_req_i(rq),
      .i2c_addr_i(ia), .i2c_write_i(iw), .cfg_o(cfg), .eq_applied_o(eqa),
      .parity_err_o(po), .fwd_o(fw), .irq_o(irq));
   dlc_far_ser ser (.clock_i(clock_i), .addr_valid_o(fv), .addr_o(fa),
      .parity_err_o(pe));
   task automatic chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   // hold the request until waitrequest is sampled low
   task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d);
      int n = 0;
      @(posedge clock_i);
      ad <= {i[5:0], 2'h0};
      wr <= w;
      rd <= !w;
      wd <= {24'h0, d};
      do begin
         @(posedge clock_i);
         n++;
      end while (wt !== 1'h0 && n < 20);
      if (n >= 20) error_cnt++;
      rv = rdw;
      rs = rsp;
      wr <= 1'h0;
      rd <= 1'h0;
   endtask : bus
   task automatic rdc(input string n, input logic [7:0] i, e);
      bus(i, 1'h0, 8'h00);
      chk(n, rv, {24'h0, e});
   endtask : rdc
   task automatic req(input logic [6:0] a, input logic w);
      @(posedge clock_i);
      rq <= 1'h1;
      ia <= a;
      iw <= w;
      @(posedge clock_i);
      rq <= 1'h0;
      #1;
   endtask : req
   task automatic t_reset();
      rdc("gen", 8'h03, 8'hE9);
      rdc("eq", 8'h04, 8'h00);
      rdc("far", 8'h06, 8'h18);
      rdc("alias", 8'h07, 8'h00);
      chk("cfg", {18'h0, cfg}, {18'h0, 6'h3B, 8'h00});
   endtask : t_reset
   task automatic t_cfg();
      bus(8'h03, 1'h1, 8'h10);
      repeat (2) @(posedge clock_i);
      chk("cfg0", {18'h0, cfg}, {18'h0, 6'h04, 8'h00});
      bus(8'h05, 1'h1, 8'hFF);
      rdc("rsvd", 8'h05, 8'h00);
      bus(8'h20, 1'h0, 8'h00);
      chk("resp", {30'h0, rs}, 32'h3);
      rdc("gen", 8'h03, 8'h10);
   endtask : t_cfg
   task automatic t_far();
      ser.announce(7'h2A);
      rdc("far", 8'h06, 8'h54);
      bus(8'h06, 1'h1, 8'h31);
      ser.announce(7'h55);
      rdc("frz", 8'h06, 8'h31);
   endtask : t_far
   // alias zero must not match an address of zero
   task automatic t_alias();
      bus(8'h03, 1'h1, 8'hE9);
      req(7'h00, 1'h0);
      chk("off", {31'h0, fw.valid}, 32'h0);
      bus(8'h07, 1'h1, 8'h44);
      req(7'h22, 1'h0);
      chk("fwd", {24'h0, fw.valid, fw.addr}, 32'h98);
      bus(8'h03, 1'h1, 8'hE1);
      req(7'h22, 1'h0);
      chk("pass", {31'h0, fw.valid}, 32'h0);
      bus(8'h03, 1'h1, 8'hED);
      req(7'h22, 1'h1);
      chk("ack", {23'h0, fw.valid, fw.early_ack, fw.addr}, 32'h198);
   endtask : t_alias
   task automatic t_par();
      bus(8'h03, 1'h1, 8'hE9);
      ser.bad_parity();
      @(posedge clock_i);
      #1;
      chk("perr", {31'h0, po}, 32'h1);
      bus(8'h11, 1'h1, 8'h00);
      @(posedge clock_i);
      i0 = irq;
      bus(8'h11, 1'h1, 8'h07);
      @(posedge clock_i);
      #1;
      chk("irq", {31'h0, irq ^ i0}, 32'h1);
      bus(8'h03, 1'h1, 8'hEB);
      @(posedge clock_i);
      chk("pclr", {31'h0, po}, 32'h0);
      rdc("self", 8'h03, 8'hE9);
      bus(8'h10, 1'h1, 8'h07);
      rdc("stat", 8'h10, 8'h00);
   endtask : t_par
   task automatic t_eq();
      bus(8'h04, 1'h1, 8'h3F);
      byp <= 1'h1;
      repeat (3) @(posedge clock_i);
      chk("eqon", {24'h0, eqa}, 32'h3F);
      byp <= 1'h0;
      repeat (2) @(posedge clock_i);
      chk("eqoff", {24'h0, eqa}, 32'h0);
   endtask : t_eq
   task automatic close_out();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (10) @(posedge clock_i);
      rst_i <= 1'h0;
      t_reset();
      t_cfg();
      t_far();
      t_alias();
      t_par();
      t_eq();
      close_out();
   end
   // watchdog: the whole run needs well under 4000 cycles
   initial begin
      #20000;
      error_cnt++;
      close_out();
   end
endmodule : dlc_regs_tb
